// ===== shared/ies_pkg.sv
// Shared constants and types for the instruction execution subset.
// Assumes an 8-bit core with an accumulator and a five-bit status set.
`default_nettype none
package ies_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int MAX_ADDR_W = 16;
  localparam int BANK_OFS_W = 8;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TABLE_POINTER_LOW_RST = 8'h00;
  localparam logic [7:0] TABLE_POINTER_HIGH_RST = 8'h00;
  localparam logic [7:0] TABLE_HIGH_BYTE_LATCH_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // Decimal adjust constants
  // ----------------------------------------------------------------
  localparam logic [3:0] NIBBLE_MAX = 4'h9;
  localparam logic [7:0] ADJ_LOW = 8'h06;
  localparam logic [7:0] ADJ_HIGH = 8'h60;

  typedef struct packed {
    logic ov;
    logic sc;
    logic ac;
    logic z;
    logic c;
  } ies_flags_t;

  localparam ies_flags_t FLAGS_RST = '0;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_COPY_AND_SKIP_IF_ZERO,
    OP_SKIP_IF_BIT_CLEAR,
    OP_TABLE_READ_PAGED,
    OP_TABLE_READ_LAST_PAGE,
    OP_INCR_TABLE_READ_PAGED,
    OP_INCR_TABLE_READ_LAST_PAGE,
    OP_XOR_TO_ACC,
    OP_XOR_IMM_TO_ACC,
    OP_EXCLUSIVE_OR_TO_MEMORY,
    OP_LONG_ADD_WITH_CARRY,
    OP_LONG_ADD_CARRY_TO_MEMORY,
    OP_LONG_SUM_TO_ACC,
    OP_LONG_SUM_TO_MEMORY,
    OP_LONG_AND_TO_ACC,
    OP_LONG_AND_TO_MEMORY,
    OP_LONG_ZERO_FILL,
    OP_LONG_ZERO_FILL_BIT,
    OP_LONG_INVERT,
    OP_LONG_INVERT_TO_ACC,
    OP_LONG_DECIMAL_ADJUST,
    OP_LONG_DECREMENT,
    OP_LONG_DECREMENT_TO_ACC,
    OP_LONG_INCREMENT,
    OP_LONG_INCREMENT_TO_ACC,
    OP_LONG_MOVE_TO_ACC,
    OP_LONG_MOVE_TO_MEMORY,
    OP_LONG_OR_TO_ACC,
    OP_LONG_OR_TO_MEMORY,
    OP_LONG_ROTATE_LEFT
  } ies_op_t;

  typedef struct packed {
    ies_op_t op;
    logic [MAX_ADDR_W-1:0] addr;
    logic [2:0] bitSel;
    logic [7:0] imm;
  } ies_instr_t;

  typedef enum logic {ST_EXEC, ST_DUMMY} ies_state_t;
endpackage : ies_pkg
`default_nettype wire

// ===== logic/ies_alu.sv
// Combinational ALU for the logic, arithmetic and long instructions.
// Assumes the caller gates writes with its own accept condition.
`default_nettype none
module ies_alu (
  // Operation
  input wire ies_pkg::ies_op_t op,
  input wire logic [2:0] bitSel,
  input wire logic [7:0] imm,
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire ies_pkg::ies_flags_t flagsIn,
  // Results
  output logic [7:0] result,
  output ies_pkg::ies_flags_t flagsOut,
  output logic toMem,
  output logic toAcc
);
  import ies_pkg::*;

  logic cin;
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic adjLow;
  logic adjHigh;
  logic [8:0] daa;

  // Carry enters only for the with-carry forms
  assign cin = (op == OP_LONG_ADD_WITH_CARRY ||
                op == OP_LONG_ADD_CARRY_TO_MEMORY) ? flagsIn.c : 1'b0;
  assign sum = {1'b0, acc} + {1'b0, mem} + {8'h00, cin};
  assign lowSum = {1'b0, acc[3:0]} + {1'b0, mem[3:0]} + {4'h0, cin};
  assign adjLow = (acc[3:0] > NIBBLE_MAX) || flagsIn.ac;
  assign adjHigh = (acc[7:4] > NIBBLE_MAX) || flagsIn.c;
  assign daa = {1'b0, acc} + {1'b0, (adjHigh ? ADJ_HIGH : ZERO_BYTE) |
                                    (adjLow ? ADJ_LOW : ZERO_BYTE)};

  always_comb begin
    result = ZERO_BYTE;
    flagsOut = flagsIn;
    toMem = 1'b0;
    toAcc = 1'b0;
    case (op)
      OP_XOR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEMORY: begin
        result = acc ^ mem;
        toMem = (op == OP_EXCLUSIVE_OR_TO_MEMORY);
        toAcc = !toMem;
      end
      OP_XOR_IMM_TO_ACC: begin
        result = acc ^ imm;
        toAcc = 1'b1;
      end
      OP_LONG_ADD_WITH_CARRY, OP_LONG_ADD_CARRY_TO_MEMORY,
      OP_LONG_SUM_TO_ACC, OP_LONG_SUM_TO_MEMORY: begin
        result = sum[7:0];
        flagsOut.c = sum[8];
        flagsOut.ac = lowSum[4];
        flagsOut.ov = (acc[7] == mem[7]) && (sum[7] != acc[7]);
        // Signed carry is the true sign of the signed sum
        flagsOut.sc = flagsOut.ov ^ sum[7];
        toMem = (op == OP_LONG_ADD_CARRY_TO_MEMORY ||
                 op == OP_LONG_SUM_TO_MEMORY);
        toAcc = !toMem;
      end
      OP_LONG_AND_TO_ACC, OP_LONG_AND_TO_MEMORY: begin
        result = acc & mem;
        toMem = (op == OP_LONG_AND_TO_MEMORY);
        toAcc = !toMem;
      end
      OP_LONG_OR_TO_ACC, OP_LONG_OR_TO_MEMORY: begin
        result = acc | mem;
        toMem = (op == OP_LONG_OR_TO_MEMORY);
        toAcc = !toMem;
      end
      OP_LONG_ZERO_FILL: begin
        result = ZERO_BYTE;
        toMem = 1'b1;
      end
      OP_LONG_ZERO_FILL_BIT: begin
        result = mem & ~(8'h01 << bitSel);
        toMem = 1'b1;
      end
      OP_LONG_INVERT, OP_LONG_INVERT_TO_ACC: begin
        result = ~mem;
        toAcc = (op == OP_LONG_INVERT_TO_ACC);
        toMem = !toAcc;
      end
      OP_LONG_DECIMAL_ADJUST: begin
        result = daa[7:0];
        // Carry can only be raised here, never dropped
        flagsOut.c = flagsIn.c | daa[8];
        toMem = 1'b1;
      end
      OP_LONG_DECREMENT, OP_LONG_DECREMENT_TO_ACC: begin
        result = mem - 8'h01;
        toAcc = (op == OP_LONG_DECREMENT_TO_ACC);
        toMem = !toAcc;
      end
      OP_LONG_INCREMENT, OP_LONG_INCREMENT_TO_ACC: begin
        result = mem + 8'h01;
        toAcc = (op == OP_LONG_INCREMENT_TO_ACC);
        toMem = !toAcc;
      end
      OP_LONG_MOVE_TO_ACC: begin
        result = mem;
        toAcc = 1'b1;
      end
      OP_LONG_MOVE_TO_MEMORY: begin
        result = acc;
        toMem = 1'b1;
      end
      OP_LONG_ROTATE_LEFT: begin
        result = {mem[6:0], mem[7]};
        toMem = 1'b1;
      end
      default: begin
        result = ZERO_BYTE;
      end
    endcase
    case (op)
      OP_XOR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEMORY, OP_XOR_IMM_TO_ACC,
      OP_LONG_ADD_WITH_CARRY, OP_LONG_ADD_CARRY_TO_MEMORY,
      OP_LONG_SUM_TO_ACC, OP_LONG_SUM_TO_MEMORY,
      OP_LONG_AND_TO_ACC, OP_LONG_AND_TO_MEMORY,
      OP_LONG_OR_TO_ACC, OP_LONG_OR_TO_MEMORY,
      OP_LONG_INVERT, OP_LONG_INVERT_TO_ACC,
      OP_LONG_DECREMENT, OP_LONG_DECREMENT_TO_ACC,
      OP_LONG_INCREMENT, OP_LONG_INCREMENT_TO_ACC: begin
        flagsOut.z = (result == ZERO_BYTE);
      end
      default: begin
        flagsOut.z = flagsIn.z;
      end
    endcase
  end
endmodule : ies_alu
`default_nettype wire

// ===== logic/ies_table_ptr.sv
// Table pointer pair and program address former for table reads.
// Assumes pointer loads come from the core's special register writes.
`default_nettype none
module ies_table_ptr #(
  parameter int PROG_ADDR_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pointer loads
  input wire logic lowWe,
  input wire logic [7:0] lowWdata,
  input wire logic highWe,
  input wire logic [PROG_ADDR_W-9:0] highWdata,
  // Table read request
  input wire logic incr,
  input wire logic lastPage,
  // Results
  output logic [PROG_ADDR_W-1:0] progAddr,
  output logic [7:0] lowPtr,
  output logic [PROG_ADDR_W-9:0] highPtr
);
  import ies_pkg::*;

  logic [7:0] lowUsed;

  // Increment is seen by the same read, not only by the next one
  assign lowUsed = incr ? lowPtr + 8'h01 : lowPtr;
  assign progAddr = lastPage ? {{(PROG_ADDR_W-8){1'b1}}, lowUsed}
                             : {highPtr, lowUsed};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lowPtr <= TABLE_POINTER_LOW_RST;
    end else if (lowWe) begin
      lowPtr <= lowWdata;
    end else if (incr) begin
      lowPtr <= lowUsed;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      highPtr <= TABLE_POINTER_HIGH_RST[PROG_ADDR_W-9:0];
    end else if (highWe) begin
      highPtr <= highWdata;
    end
  end
endmodule : ies_table_ptr
`default_nettype wire

// ===== logic/ies_exec.sv
// Execution unit for skip, table read, XOR and long data instructions.
// Assumes combinational data and program memory reads in the same cycle
// and a fetch stage that honours instrReady and the dummy cycle.
`default_nettype none
// Operation
// - Copy byte to accumulator, skip if zero
// - Taken skip inserts one dummy cycle
// - Skip when selected data bit is clear
// - Paged table read uses both pointers
// - Last-page table read uses low pointer
// - Increment low pointer, then paged read
// - Increment low pointer, then last-page read
// - XOR into accumulator or memory, Z only
// - Long forms address all data memory
// - Add with carry, five arithmetic flags
// - Add without carry, same five flags
// - AND into accumulator or memory, Z only
// - OR into accumulator or memory, Z only
// - Clear byte or bit, no flags
// - Complement to memory or accumulator, Z
// - Decimal adjust accumulator into memory, carry only
// - Decrement to memory or accumulator, Z
// - Increment to memory or accumulator, Z
// - Move byte either way, no flags
// - Rotate byte left, bit 7 to 0
module ies_exec #(
  parameter int MEM_ADDR_W = 12,
  parameter int PROG_ADDR_W = 16,
  parameter int PROG_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction stream
  input wire logic instrValid,
  input wire ies_pkg::ies_instr_t instr,
  output logic instrReady,
  output logic skipTaken,
  output logic dummyCycle,
  // Bank select for short forms
  input wire logic [MEM_ADDR_W-9:0] bankSel,
  // Data memory
  output logic [MEM_ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  output logic memWe,
  output logic [MEM_ADDR_W-1:0] memWrAddr,
  output logic [7:0] memWrData,
  // Program memory
  output logic [PROG_ADDR_W-1:0] progAddr,
  input wire logic [PROG_W-1:0] progWord,
  // Table pointer loads
  input wire logic tblpWe,
  input wire logic [7:0] tblpWdata,
  input wire logic tbhpWe,
  input wire logic [PROG_ADDR_W-9:0] tbhpWdata,
  // Core state
  output logic [7:0] acc,
  output ies_pkg::ies_flags_t flags,
  output logic [PROG_W-9:0] tableHigh,
  output logic [7:0] tablePtrLow,
  output logic [PROG_ADDR_W-9:0] tablePtrHigh
);
  import ies_pkg::*;

  if (MEM_ADDR_W < 9 || MEM_ADDR_W > MAX_ADDR_W || PROG_ADDR_W < 9 ||
      PROG_ADDR_W > 16 || PROG_W < 9 || PROG_W > 16) begin : g_bad_params
    $error("ies_exec: unsupported width parameters");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic isLong(input ies_op_t op);
    return op >= OP_LONG_ADD_WITH_CARRY;
  endfunction : isLong

  function automatic logic isTable(input ies_op_t op);
    return op == OP_TABLE_READ_PAGED || op == OP_TABLE_READ_LAST_PAGE ||
           op == OP_INCR_TABLE_READ_PAGED ||
           op == OP_INCR_TABLE_READ_LAST_PAGE;
  endfunction : isTable

  ies_state_t state_q;
  ies_state_t state_d;
  logic accepted;
  logic [MEM_ADDR_W-1:0] effAddr;
  logic [7:0] operand;
  logic [7:0] aluResult;
  ies_flags_t aluFlags;
  logic aluToMem;
  logic aluToAcc;
  logic skipCond;

  // Long forms see the whole space; short forms stay in the bank
  assign effAddr = isLong(instr.op) ? instr.addr[MEM_ADDR_W-1:0]
                                    : {bankSel, instr.addr[7:0]};
  assign memRdAddr = effAddr;

  // Forward a write still in flight so back-to-back ops see fresh data
  assign operand = (memWe && memWrAddr == effAddr) ? memWrData
                                                    : memRdData;

  // The skipped instruction arrives in the dummy cycle and is dropped
  assign instrReady = 1'b1;
  assign accepted = instrValid && (state_q == ST_EXEC);
  assign dummyCycle = (state_q == ST_DUMMY);

  always_comb begin
    case (instr.op)
      OP_COPY_AND_SKIP_IF_ZERO: skipCond = (operand == ZERO_BYTE);
      OP_SKIP_IF_BIT_CLEAR: skipCond = !operand[instr.bitSel];
      default: skipCond = 1'b0;
    endcase
  end
  assign skipTaken = accepted && skipCond;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  ies_alu u_alu (
    .op(instr.op),
    .bitSel(instr.bitSel),
    .imm(instr.imm),
    .acc(acc),
    .mem(operand),
    .flagsIn(flags),
    .result(aluResult),
    .flagsOut(aluFlags),
    .toMem(aluToMem),
    .toAcc(aluToAcc)
  );

  ies_table_ptr #(
    .PROG_ADDR_W(PROG_ADDR_W)
  ) u_table_ptr (
    .clock(clock),
    .rst(rst),
    .lowWe(tblpWe),
    .lowWdata(tblpWdata),
    .highWe(tbhpWe),
    .highWdata(tbhpWdata),
    .incr(accepted && (instr.op == OP_INCR_TABLE_READ_PAGED ||
          instr.op == OP_INCR_TABLE_READ_LAST_PAGE)),
    .lastPage(instr.op == OP_TABLE_READ_LAST_PAGE ||
              instr.op == OP_INCR_TABLE_READ_LAST_PAGE),
    .progAddr(progAddr),
    .lowPtr(tablePtrLow),
    .highPtr(tablePtrHigh)
  );

  // ----------------------------------------------------------------
  // Skip sequencing
  // ----------------------------------------------------------------
  always_comb begin
    case (state_q)
      ST_EXEC: state_d = skipTaken ? ST_DUMMY : ST_EXEC;
      ST_DUMMY: state_d = ST_EXEC;
      default: state_d = ST_EXEC;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc <= ACC_RST;
    end else if (accepted) begin
      if (instr.op == OP_COPY_AND_SKIP_IF_ZERO) begin
        acc <= operand;
      end else if (aluToAcc) begin
        acc <= aluResult;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RST;
    end else if (accepted) begin
      flags <= aluFlags;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tableHigh <= TABLE_HIGH_BYTE_LATCH_RST[PROG_W-9:0];
    end else if (accepted && isTable(instr.op)) begin
      tableHigh <= progWord[PROG_W-1:8];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      memWe <= 1'b0;
      memWrAddr <= '0;
      memWrData <= ZERO_BYTE;
    end else begin
      memWe <= accepted && (aluToMem || isTable(instr.op));
      if (accepted) begin
        memWrAddr <= effAddr;
        memWrData <= isTable(instr.op) ? progWord[7:0]
                                       : aluResult;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_copy_load: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_COPY_AND_SKIP_IF_ZERO |=>
      acc == $past(operand) && flags == $past(flags))
    else $error("copy and skip did not load accumulator");

  chk_skip_dummy: assert property (@(posedge clock) disable iff (rst)
    skipTaken |=> dummyCycle ##1 !dummyCycle)
    else $error("taken skip did not give one dummy cycle");

  chk_bit_skip: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_SKIP_IF_BIT_CLEAR |->
      skipTaken == !operand[instr.bitSel])
    else $error("bit skip decision wrong");

  chk_table_paged: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_TABLE_READ_PAGED |->
      progAddr == {tablePtrHigh, tablePtrLow} ##1
      memWe && memWrData == $past(progWord[7:0]) &&
      tableHigh == $past(progWord[PROG_W-1:8]))
    else $error("paged table read wrong");

  chk_table_last: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_TABLE_READ_LAST_PAGE |->
      progAddr == {{(PROG_ADDR_W-8){1'b1}}, tablePtrLow})
    else $error("last page table address wrong");

  chk_incr_ptr: assert property (@(posedge clock) disable iff (rst)
    accepted && !tblpWe && instr.op == OP_INCR_TABLE_READ_PAGED |->
      progAddr[7:0] == tablePtrLow + 8'h01 ##1
      tablePtrLow == $past(tablePtrLow) + 8'h01)
    else $error("incrementing table read pointer wrong");

  chk_incr_last: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_INCR_TABLE_READ_LAST_PAGE |->
      progAddr == {{(PROG_ADDR_W-8){1'b1}}, tablePtrLow + 8'h01})
    else $error("incrementing last page address wrong");

  chk_xor_zero: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_XOR_TO_ACC |=>
      acc == ($past(acc) ^ $past(operand)) && flags.z == (acc == 8'h00) &&
      {flags.ov, flags.sc, flags.ac, flags.c} ==
      $past({flags.ov, flags.sc, flags.ac, flags.c}))
    else $error("xor result or flags wrong");

  chk_long_addr: assert property (@(posedge clock) disable iff (rst)
    accepted && isLong(instr.op) |->
      memRdAddr == instr.addr[MEM_ADDR_W-1:0])
    else $error("long form did not use full address");

  chk_add_carry: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_LONG_ADD_WITH_CARRY |=>
      {flags.c, acc} == {1'b0, $past(acc)} + {1'b0, $past(operand)} +
      {8'h00, $past(flags.c)})
    else $error("add with carry wrong");

  chk_zero_fill: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_LONG_ZERO_FILL |=>
      memWe && memWrData == 8'h00 && $stable(flags))
    else $error("clear wrote wrong value or moved flags");

  chk_rotate: assert property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_LONG_ROTATE_LEFT |=>
      memWrData == {$past(operand[6:0]), $past(operand[7])} &&
      $stable(flags))
    else $error("rotate left wrong");

  chk_dummy_drop: assert property (@(posedge clock) disable iff (rst)
    dummyCycle |=> $stable(acc) && $stable(flags) && !memWe &&
      $stable(tableHigh))
    else $error("dummy cycle changed state");

  cov_skip_taken: cover property (@(posedge clock) disable iff (rst)
    skipTaken ##1 dummyCycle && instrValid);
  cov_table_incr: cover property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_INCR_TABLE_READ_LAST_PAGE);
  cov_decimal_adj: cover property (@(posedge clock) disable iff (rst)
    accepted && instr.op == OP_LONG_DECIMAL_ADJUST && aluFlags.c);
endmodule : ies_exec
`default_nettype wire

// ===== tb/ies_mem_model.sv
// Behavioural data and program memory beside the execution unit.
// Assumes combinational reads and writes on the rising clock edge.
`default_nettype none
module ies_mem_model #(
  parameter int MEM_ADDR_W = 12,
  parameter int PROG_ADDR_W = 16,
  parameter int PROG_W = 16
) (
  // Clock
  input wire logic clock,
  // Data memory
  input wire logic [MEM_ADDR_W-1:0] memRdAddr,
  output logic [7:0] memRdData,
  input wire logic memWe,
  input wire logic [MEM_ADDR_W-1:0] memWrAddr,
  input wire logic [7:0] memWrData,
  // Program memory
  input wire logic [PROG_ADDR_W-1:0] progAddr,
  output logic [PROG_W-1:0] progWord
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [2**MEM_ADDR_W];
  initial for (int i = 0; i < 2**MEM_ADDR_W; i++) mem[i] = 8'(i);
  assign memRdData = mem[memRdAddr];
  // Scrambled address: table words predictable yet distinct
  assign progWord = PROG_W'(progAddr) ^ PROG_W'(16'h5ac3);
  always @(posedge clock) begin
    if (memWe) mem[memWrAddr] <= memWrData;
  end
endmodule : ies_mem_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the execution unit and its memory model.
// Assumes default widths: 12-bit data address, 16-bit program word.
`default_nettype none
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ies_pkg::*;
  localparam logic [11:0] SCRATCH = 12'hfff;
  localparam logic [7:0] PAT = 8'ha5;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  ies_instr_t instr = '0;
  logic [3:0] bankSel = 4'hb;
  logic tblpWe = 1'b0, tbhpWe = 1'b0;
  logic [7:0] tblpWdata = 8'h00, tbhpWdata = 8'h00;
  logic instrReady, skipTaken, dummyCycle, memWe;
  logic [11:0] memRdAddr, memWrAddr;
  logic [7:0] memRdData, memWrData, acc, tableHigh, tablePtrLow, tablePtrHigh;
  logic [15:0] progAddr, progWord;
  ies_flags_t flags;
  ies_flags_t ef = '0;
  int n_fail = 0;
  int tests_run = 0;

  ies_exec #(.MEM_ADDR_W(12), .PROG_ADDR_W(16), .PROG_W(16)) u_ies_exec (
    .clock(clock), .rst(rst), .instrValid(instrValid), .instr(instr),
    .instrReady(instrReady), .skipTaken(skipTaken), .dummyCycle(dummyCycle),
    .bankSel(bankSel), .memRdAddr(memRdAddr), .memRdData(memRdData),
    .memWe(memWe), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .progAddr(progAddr), .progWord(progWord), .tblpWe(tblpWe),
    .tblpWdata(tblpWdata), .tbhpWe(tbhpWe), .tbhpWdata(tbhpWdata),
    .acc(acc), .flags(flags), .tableHigh(tableHigh),
    .tablePtrLow(tablePtrLow), .tablePtrHigh(tablePtrHigh));
  ies_mem_model u_ies_mem_model (
    .clock(clock), .memRdAddr(memRdAddr), .memRdData(memRdData),
    .memWe(memWe), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .progAddr(progAddr), .progWord(progWord));

  always #2.5 clock = ~clock;

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [11:0] effAddr(ies_op_t o, logic [15:0] a);
    if (o inside {[OP_COPY_AND_SKIP_IF_ZERO:OP_EXCLUSIVE_OR_TO_MEMORY]})
      return {bankSel, a[7:0]};
    return a[11:0];
  endfunction : effAddr

  function automatic logic [8:0] ref9(ies_op_t o, logic [7:0] a, m,
      logic [2:0] b, ies_flags_t f);
    logic [7:0] adj;
    adj = {(a[7:4] > 4'h9 || f.c) ? 4'h6 : 4'h0,
           (a[3:0] > 4'h9 || f.ac) ? 4'h6 : 4'h0};
    case (o)
      OP_LONG_ADD_WITH_CARRY, OP_LONG_ADD_CARRY_TO_MEMORY:
        return 9'(a) + 9'(m) + 9'(f.c);
      OP_LONG_SUM_TO_ACC, OP_LONG_SUM_TO_MEMORY: return 9'(a) + 9'(m);
      OP_XOR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEMORY: return {1'b0, a ^ m};
      OP_XOR_IMM_TO_ACC: return {1'b0, a ^ 8'h3c};
      OP_LONG_AND_TO_ACC, OP_LONG_AND_TO_MEMORY: return {1'b0, a & m};
      OP_LONG_OR_TO_ACC, OP_LONG_OR_TO_MEMORY: return {1'b0, a | m};
      OP_LONG_ZERO_FILL: return 9'h000;
      OP_LONG_ZERO_FILL_BIT: return {1'b0, m & ~(8'h01 << b)};
      OP_LONG_INVERT, OP_LONG_INVERT_TO_ACC: return {1'b0, ~m};
      OP_LONG_DECIMAL_ADJUST: return 9'(a) + 9'(adj);
      OP_LONG_DECREMENT, OP_LONG_DECREMENT_TO_ACC: return {1'b0, m - 8'h01};
      OP_LONG_INCREMENT, OP_LONG_INCREMENT_TO_ACC: return {1'b0, m + 8'h01};
      OP_LONG_MOVE_TO_MEMORY: return {1'b0, a};
      OP_LONG_ROTATE_LEFT: return {1'b0, m[6:0], m[7]};
      default: return {1'b0, m};
    endcase
  endfunction : ref9

  function automatic ies_flags_t refFlags(ies_op_t o, logic [7:0] a, m,
      ies_flags_t f, logic [8:0] r);
    ies_flags_t n;
    n = f;
    if (o inside {[OP_LONG_ADD_WITH_CARRY:OP_LONG_SUM_TO_MEMORY]}) begin
      n.c = r[8];
      n.ac = a[4] ^ m[4] ^ r[4];
      n.ov = (a[7] == m[7]) && (r[7] != a[7]);
      n.sc = n.ov ^ r[7];
      n.z = (r[7:0] == 8'h00);
    end else if (o inside {[OP_XOR_TO_ACC:OP_EXCLUSIVE_OR_TO_MEMORY],
        OP_LONG_AND_TO_ACC, OP_LONG_AND_TO_MEMORY, OP_LONG_OR_TO_ACC,
        OP_LONG_OR_TO_MEMORY, OP_LONG_INVERT, OP_LONG_INVERT_TO_ACC,
        [OP_LONG_DECREMENT:OP_LONG_INCREMENT_TO_ACC]})
      n.z = (r[7:0] == 8'h00);
    else if (o == OP_LONG_DECIMAL_ADJUST)
      n.c = f.c | r[8];
    return n;
  endfunction : refFlags

  function automatic bit toMem(ies_op_t o);
    return o inside {OP_EXCLUSIVE_OR_TO_MEMORY, OP_LONG_ADD_CARRY_TO_MEMORY,
      OP_LONG_SUM_TO_MEMORY, OP_LONG_AND_TO_MEMORY, OP_LONG_ZERO_FILL,
      OP_LONG_ZERO_FILL_BIT, OP_LONG_INVERT, OP_LONG_DECIMAL_ADJUST,
      OP_LONG_DECREMENT, OP_LONG_INCREMENT, OP_LONG_MOVE_TO_MEMORY,
      OP_LONG_OR_TO_MEMORY, OP_LONG_ROTATE_LEFT};
  endfunction : toMem

  // ----------------------------------------------------------------
  // Drivers and scenarios
  // ----------------------------------------------------------------
  task automatic issue(ies_op_t o, logic [15:0] a, logic [2:0] b = 3'h0);
    @(posedge clock);
    instr <= '{o, a, b, 8'h3c};
    instrValid <= 1'b1;
  endtask : issue

  task automatic run1(ies_op_t o, logic [15:0] a, logic [2:0] b = 3'h0);
    issue(o, a, b);
    @(posedge clock);
    instrValid <= 1'b0;
    #1;
  endtask : run1

  task automatic setAcc(logic [7:0] v);
    u_ies_mem_model.mem[SCRATCH] = v;
    run1(OP_LONG_MOVE_TO_ACC, {4'h0, SCRATCH});
    `CHK(acc, v)
    `CHK(flags, ef)
  endtask : setAcc

  // Operand poked after setAcc so a pending write cannot overwrite it
  task automatic tryOp(ies_op_t o, logic [7:0] a, m, logic [2:0] b = 3'h0);
    logic [11:0] ea;
    logic [8:0] r;
    setAcc(a);
    ea = effAddr(o, 16'h0537);
    r = ref9(o, a, m, b, ef);
    u_ies_mem_model.mem[ea] = m;
    run1(o, 16'h0537, b);
    ef = refFlags(o, a, m, ef, r);
    `CHK(flags, ef)
    `CHK(memWe, toMem(o))
    if (toMem(o)) begin
      `CHK(memWrAddr, ea)
      `CHK(memWrData, r[7:0])
      `CHK(acc, a)
    end else
      `CHK(acc, r[7:0])
  endtask : tryOp

  task automatic trySkip(ies_op_t o, logic [7:0] m, logic [2:0] b, bit skip);
    logic [7:0] prior;
    setAcc(8'h11);
    u_ies_mem_model.mem[{bankSel, 8'h37}] = m;
    u_ies_mem_model.mem[12'h0aa] = 8'h3c;
    prior = (o == OP_COPY_AND_SKIP_IF_ZERO) ? m : 8'h11;
    issue(o, 16'h0037, b);
    #1;
    `CHK(skipTaken, skip)
    issue(OP_LONG_MOVE_TO_ACC, 16'h00aa);
    #1;
    `CHK(dummyCycle, skip)
    `CHK(instrReady, 1'b1)
    @(posedge clock);
    instrValid <= 1'b0;
    #1;
    `CHK(acc, skip ? prior : 8'h3c)
    `CHK(flags, ef)
  endtask : trySkip

  task automatic tryTable(ies_op_t o, logic [7:0] lo, hi);
    logic [7:0] nlo;
    logic [15:0] w;
    nlo = lo + ((o inside {OP_INCR_TABLE_READ_PAGED,
      OP_INCR_TABLE_READ_LAST_PAGE}) ? 8'h01 : 8'h00);
    w = {(o inside {OP_TABLE_READ_LAST_PAGE,
      OP_INCR_TABLE_READ_LAST_PAGE}) ? 8'hff : hi, nlo} ^ 16'h5ac3;
    @(posedge clock);
    tblpWe <= 1'b1;
    tblpWdata <= lo;
    tbhpWe <= 1'b1;
    tbhpWdata <= hi;
    @(posedge clock);
    tblpWe <= 1'b0;
    tbhpWe <= 1'b0;
    run1(o, 16'h0042);
    `CHK(tablePtrLow, nlo)
    `CHK(tablePtrHigh, hi)
    `CHK(tableHigh, w[15:8])
    `CHK(memWe, 1'b1)
    `CHK(memWrAddr, {bankSel, 8'h42})
    `CHK(memWrData, w[7:0])
    `CHK(flags, ef)
  endtask : tryTable

  task automatic end_sim;
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    tryOp(OP_LONG_SUM_TO_ACC, 8'hff, 8'h01);
    tryOp(OP_LONG_ADD_WITH_CARRY, 8'h7f, 8'h00);
    tryOp(OP_LONG_SUM_TO_MEMORY, 8'hff, 8'hff);
    tryOp(OP_LONG_ADD_CARRY_TO_MEMORY, 8'h3f, 8'h40);
    tryOp(OP_LONG_DECIMAL_ADJUST, 8'h38, 8'h00);
    tryOp(OP_LONG_DECIMAL_ADJUST, 8'haa, 8'h00);
    tryOp(OP_LONG_DECIMAL_ADJUST, 8'h12, 8'h00);
    tryOp(OP_XOR_TO_ACC, 8'h5a, 8'h5a);
    tryOp(OP_XOR_IMM_TO_ACC, 8'h5a, 8'hc3);
    tryOp(OP_EXCLUSIVE_OR_TO_MEMORY, 8'h5a, 8'hc3);
    tryOp(OP_LONG_AND_TO_ACC, 8'h5a, 8'ha5);
    tryOp(OP_LONG_AND_TO_MEMORY, 8'h5a, 8'hc3);
    tryOp(OP_LONG_OR_TO_ACC, 8'h5a, 8'hc3);
    tryOp(OP_LONG_OR_TO_MEMORY, 8'h00, 8'h00);
    tryOp(OP_LONG_ZERO_FILL, 8'h5a, 8'ha5);
    tryOp(OP_LONG_ZERO_FILL_BIT, 8'h5a, 8'hff, 3'h7);
    tryOp(OP_LONG_INVERT, 8'h5a, 8'hff);
    tryOp(OP_LONG_INVERT_TO_ACC, 8'h5a, 8'h3c);
    tryOp(OP_LONG_DECREMENT, 8'h5a, 8'h00);
    tryOp(OP_LONG_DECREMENT_TO_ACC, 8'h5a, 8'h01);
    tryOp(OP_LONG_INCREMENT, 8'h5a, 8'hff);
    tryOp(OP_LONG_INCREMENT_TO_ACC, 8'h5a, 8'h7f);
    tryOp(OP_LONG_MOVE_TO_MEMORY, 8'h96, 8'h00);
    tryOp(OP_LONG_ROTATE_LEFT, 8'h5a, 8'h81);
    trySkip(OP_COPY_AND_SKIP_IF_ZERO, 8'h00, 3'h0, 1'b1);
    trySkip(OP_COPY_AND_SKIP_IF_ZERO, 8'h80, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++)
      trySkip(OP_SKIP_IF_BIT_CLEAR, PAT, 3'(i), !PAT[i]);
    tryTable(OP_TABLE_READ_PAGED, 8'h34, 8'h12);
    tryTable(OP_TABLE_READ_LAST_PAGE, 8'h34, 8'h12);
    tryTable(OP_INCR_TABLE_READ_PAGED, 8'hff, 8'h12);
    tryTable(OP_INCR_TABLE_READ_LAST_PAGE, 8'h7f, 8'h00);
    end_sim();
  end

  // Run is under two hundred cycles; ample margin
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
